/* File: testbench/pcf_flags_props.sv */
// Concurrent checks on the completion flag block ports
`timescale 1ns/10ps
module pcf_flags_props (
    // Clock, reset and drive status
    input wire logic        REF_CLK_IN, RST_B_IN, SERVO_ON_IN, POS_MODE_IN,
    input wire logic [31:0] DEV_ENC_IN, DEV_REF_IN,
    input wire logic        REF_FILT_ZERO_IN, REF_ZERO_IN, MULTI_REF_ZERO_IN,
    input wire logic        INT_POS_DONE_IN, NEW_REF_IN,
    // Register port
    input wire logic [7:0]  ADDR_IN,
    input wire logic [31:0] WDATA_IN, RDATA_OUT,
    input wire logic        WR_IN, RD_IN,
    // Outputs
    input wire logic        DONE_DO_OUT, SENT_DO_OUT, REACHED_DO_OUT, PROXIMITY_FLAG_DO_OUT, IRQ_OUT
);
    logic [3:0] pol;
    logic [3:0] pd;
    // Polarity shadow, delayed so it lines up with the output stage
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            pol <= 4'h0;
            pd  <= 4'h0;
        end else begin
            if (WR_IN && ADDR_IN == 8'h14) pol <= WDATA_IN[3:0];
            pd <= pol;
        end
    end
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (!RST_B_IN);
    sequence s_servo_off; !SERVO_ON_IN [*3]; endsequence
    sequence s_mode_off; !POS_MODE_IN [*4]; endsequence
    sequence s_unsent; (!MULTI_REF_ZERO_IN && !INT_POS_DONE_IN) [*4]; endsequence
    AST_PROXIMITY_FLAG_OFF:
    assert property (s_servo_off |-> !(PROXIMITY_FLAG_DO_OUT ^ pd[3]))
        else $error("proximity with servo off");
    AST_REACH_OFF:
    assert property (s_servo_off |-> !(REACHED_DO_OUT ^ pd[2]))
        else $error("reached with servo off");
    AST_SENT:
    assert property (POS_MODE_IN |-> ##2 ((SENT_DO_OUT ^ pd[1]) ==
        $past(MULTI_REF_ZERO_IN || INT_POS_DONE_IN, 2))) else $error("sent flag wrong");
    AST_PROXIMITY_FLAG_ZERO:
    assert property (SERVO_ON_IN && DEV_ENC_IN == 32'h0 && DEV_REF_IN == 32'h0 |-> ##2
        (PROXIMITY_FLAG_DO_OUT ^ pd[3])) else $error("proximity missing at zero deviation");
    AST_DONE_MODE:
    assert property (s_mode_off |-> !(DONE_DO_OUT ^ pd[0])) else $error("done outside mode");
    AST_DONE_SENT:
    assert property (s_unsent |-> !(DONE_DO_OUT ^ pd[0])) else $error("done before sent");
    AST_RD_IDLE:
    assert property (!RD_IN |=> RDATA_OUT == 32'h0) else $error("read data without read");
    AST_RD_UNMAPPED:
    assert property (RD_IN && ADDR_IN > 8'h24 |=> RDATA_OUT == 32'h0) else $error("unmapped read");
endmodule // pcf_flags_props
bind pcf_flags pcf_flags_props i_props (.*);

/* File: testbench/pcf_host.sv */
// Host controller model reading the four status outputs
`timescale 1ns/10ps
module pcf_host (
    // Clock and output pins
    input  wire logic       clk_in,
    input  wire logic [3:0] do_in,
    // Active level configured per output
    input  wire logic [3:0] pol_in,
    // Decoded state seen by the host
    output logic      [3:0] active_out
);
    // Registered input stage, so the host lags the pins by a cycle
    always_ff @(posedge clk_in) begin
        active_out <= do_in ^ pol_in;
    end
endmodule // pcf_host

/* File: testbench/tb_positioning_completion_flags.sv */
// Self-checking bench for the completion flag block
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch %s expected %h seen %h", n, e, g); end end
module tb_positioning_completion_flags;
    logic        clk = 0, rst_b = 0, servo = 0, mode = 0, filt = 0, refz = 0;
    logic        mref = 0, ipd = 0, nref = 0, wr = 0, rd = 0, irq;
    logic [7:0]  ad = 8'h00;
    logic [31:0] denc = 0, dref = 0, wd = 0, rdata, v;
    wire  [3:0]  dov;
    logic [3:0]  act, polv = 4'h0;
    logic [4:0]  tbl [7] = '{5'h01, 5'h0A, 5'h0D, 5'h14, 5'h13, 5'h18, 5'h1B};
    int          n_mismatch = 0, check_count = 0;
    // Short tick keeps millisecond counts cheap
    pcf_flags #(.TICK_CYCLES(10)) i_dut (
        .REF_CLK_IN(clk), .RST_B_IN(rst_b), .SERVO_ON_IN(servo), .POS_MODE_IN(mode),
        .DEV_ENC_IN(denc), .DEV_REF_IN(dref), .REF_FILT_ZERO_IN(filt), .REF_ZERO_IN(refz),
        .MULTI_REF_ZERO_IN(mref), .INT_POS_DONE_IN(ipd), .NEW_REF_IN(nref), .ADDR_IN(ad),
        .WDATA_IN(wd), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .DONE_DO_OUT(dov[0]),
        .SENT_DO_OUT(dov[1]), .REACHED_DO_OUT(dov[2]), .PROXIMITY_FLAG_DO_OUT(dov[3]), .IRQ_OUT(irq));
    pcf_host i_host (.clk_in(clk), .do_in(dov), .pol_in(polv), .active_out(act));
    initial forever #2 clk = ~clk;
    task automatic final_report;
        if (n_mismatch == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // One-cycle strobes; read data is taken in the cycle after
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk); ad <= a; wd <= d; wr <= 1'b1;
        @(posedge clk); wr <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk); ad <= a; rd <= 1'b1;
        @(posedge clk); rd <= 1'b0;
        #1 `CHK("rdata", e, rdata)
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic dev(input logic [31:0] e, input logic [31:0] r);
        @(posedge clk); denc <= e; dref <= r;
    endtask
    // Large deviation plus a new reference drops the reached flag
    task automatic clr;
        @(posedge clk); denc <= 32'h3E8; dref <= 32'h3E8; nref <= 1'b1;
        @(posedge clk); nref <= 1'b0;
    endtask
    task automatic tryd(input logic [31:0] e, input logic [31:0] r, input logic x);
        clr(); dev(e, r); cyc(6);
        `CHK("reached", x, act[2])
    endtask
    // Bounded wait; running out ends the run
    task automatic waitf(input int i, input logic x, input int lim);
        repeat (lim) if (act[i] !== x) begin @(posedge clk); #1; end
        if (act[i] !== x) begin
            n_mismatch++;
            $display("mismatch wait expected %h seen %h", x, act[i]);
            final_report();
        end
    endtask
    initial begin
        v = $urandom(32'h2279_8974);
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        rchk(8'h04, 32'h0000_16F0);
        rchk(8'h08, 32'h0000_FFFF);
        rchk(8'h00, 32'h0000_0000);
        rchk(8'h3C, 32'h0000_0000);
        rchk(8'h20, 32'h0000_0000);
        wreg(8'h04, 32'h0); rchk(8'h04, 32'h0000_0001);
        wreg(8'h0C, 32'hFFFF); rchk(8'h0C, 32'h0000_7530);
        wreg(8'h10, 32'hFFFF); rchk(8'h10, 32'h0000_7530);
        wreg(8'h0C, 32'h0); wreg(8'h10, 32'h0); wreg(8'h04, 32'h32);
        wreg(8'h08, 32'h64);
        servo <= 1'b1; mode <= 1'b1;
        // Every qualifying condition, random deviation inside the threshold
        foreach (tbl[k]) begin
            clr(); wreg(8'h00, {30'h0, tbl[k][4:3]});
            filt <= tbl[k][2]; refz <= tbl[k][1];
            v = $urandom_range(49);
            dev(v[0] ? -v : v, v[0] ? -v : v); cyc(6);
            `CHK("cond", tbl[k][0], act[2])
        end
        wreg(8'h00, 32'h0);
        tryd(32'h32, 32'h32, 1'b0);
        tryd(-32'h31, -32'h31, 1'b1);
        dev(32'h64, 32'h64); cyc(6); `CHK("proximity_flag", 1'b1, act[3])
        dev(-32'h65, -32'h65); cyc(6); `CHK("proximity_flag", 1'b0, act[3])
        wreg(8'h00, 32'h4); tryd(32'hA, 32'h1F4, 1'b0);
        tryd(32'h1F4, 32'hA, 1'b1);
        wreg(8'h00, 32'h0); tryd(32'h0, 32'h0, 1'b1);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk); mref <= i[0]; ipd <= i[1]; cyc(6);
            `CHK("sent", |i[1:0], act[1])
            `CHK("done", |i[1:0], act[0])
        end
        wreg(8'h14, 32'hF); polv <= 4'hF; cyc(6);
        `CHK("raw", 4'h0, dov)
        `CHK("act", 4'hF, act)
        wreg(8'h14, 32'h0); polv <= 4'h0;
        @(posedge clk); servo <= 1'b0; cyc(6);
        `CHK("off", 2'b00, act[3:2])
        @(posedge clk); servo <= 1'b1;
        // Window delays the flag; hold keeps it after the condition drops
        wreg(8'h0C, 32'h3); clr(); dev(32'h0, 32'h0); cyc(12);
        `CHK("window", 1'b0, act[2])
        dev(32'h3E8, 32'h3E8); dev(32'h0, 32'h0); cyc(18);
        `CHK("restart", 1'b0, act[2])
        waitf(2, 1'b1, 60);
        wreg(8'h0C, 32'h0); wreg(8'h10, 32'h2); dev(32'h3E8, 32'h3E8); cyc(3);
        `CHK("hold", 1'b1, act[2])
        waitf(2, 1'b0, 60);
        wreg(8'h10, 32'h0); dev(32'h0, 32'h0); cyc(6); dev(32'h3E8, 32'h3E8); cyc(40);
        `CHK("keep", 1'b1, act[2])
        clr(); cyc(6);
        `CHK("next", 1'b0, act[2])
        // Interrupt raised, cleared, then masked
        wreg(8'h20, 32'hF); wreg(8'h24, 32'h4); cyc(3);
        `CHK("irq", 1'b0, irq)
        dev(32'h0, 32'h0); cyc(8);
        `CHK("irq", 1'b1, irq)
        clr(); wreg(8'h20, 32'hF); wreg(8'h24, 32'h0); cyc(3);
        `CHK("irq", 1'b0, irq)
        dev(32'h0, 32'h0); cyc(8);
        `CHK("irq", 1'b0, irq)
        rchk(8'h1C, 32'h0000_000D);
        final_report();
    end
endmodule // tb_positioning_completion_flags

/* File: verilog/pcf_flags.v */
// Position completion flags: motion done, command sent, reached and proximity
`timescale 1ns/10ps
`include "pcf_map.vh"

// Function
// RULE1: Motion-done asserts only after reference sent and positioning finished, position mode.
// RULE2: Command-sent asserts when internal multi-position reference has reached zero.
// RULE3: Completed interrupt-positioning reference counts as completed reference for both.
// RULE4: Reached flag needs position mode and the selected qualifying condition.
// RULE5: Select 0 below threshold; 1 filtered ref zero; 2 ref zero; 3 held.
// RULE6: Proximity flag asserts when absolute deviation meets proximity threshold.
// RULE7: Thresholds accept 1 to 65535; defaults 5872 and 65535.
// RULE8: Unit select chooses encoder (0) or reference (1) deviation; default 0.
// RULE9: Reach condition filtered by window time 0-30000 ms before output.
// RULE10: Active reached flag held for hold time 0-30000 ms.
// RULE11: Hold time zero keeps reached flag until next position reference.
// RULE12: Servo-on inactive forces reached and proximity flags inactive.
// RULE13: Each flag drives its own output with configurable active level.
// RULE14: Software should set proximity threshold above reach threshold.
// RULE15: Counters advance on millisecond tick; window restarts when condition drops.
module pcf_flags #(
    parameter TICK_CYCLES = `PCF_TICK_CYCLES
) (
    // Clock and reset
    input  wire        REF_CLK_IN,
    input  wire        RST_B_IN,
    // Drive status
    input  wire        SERVO_ON_IN,
    input  wire        POS_MODE_IN,
    input  wire [31:0] DEV_ENC_IN,
    input  wire [31:0] DEV_REF_IN,
    input  wire        REF_FILT_ZERO_IN,
    input  wire        REF_ZERO_IN,
    input  wire        MULTI_REF_ZERO_IN,
    input  wire        INT_POS_DONE_IN,
    input  wire        NEW_REF_IN,
    // Register port
    input  wire [7:0]  ADDR_IN,
    input  wire [31:0] WDATA_IN,
    input  wire        WR_IN,
    input  wire        RD_IN,
    output reg  [31:0] RDATA_OUT,
    // Digital outputs and interrupt
    output reg         DONE_DO_OUT,
    output reg         SENT_DO_OUT,
    output reg         REACHED_DO_OUT,
    output reg         PROXIMITY_FLAG_DO_OUT,
    output reg         IRQ_OUT
);

    // Tick counter width; 18 bits hold the 1 ms count at 250 MHz.
    // A slower tick or a faster clock needs this widened as well.
    localparam TW = 18;

    // Configuration registers
    // All settings act from the edge after the write strobe; thresholds
    // never hold zero, since the write path lifts zero to one.
    reg [1:0]    cond_sel;
    reg          unit_sel;
    reg [15:0]   reach_thr;
    reg [15:0]   proximity_flag_thr;
    reg [14:0]   window_ms;
    reg [14:0]   hold_ms;
    reg [3:0]    polarity;
    reg [3:0]    irq_status;
    reg [3:0]    irq_enable;

    // Flag state
    // Each internal flag leads its pin by one cycle, because the pin is
    // a flip-flop behind the polarity inversion.
    reg          command_sent_flag;
    reg          motion_done_flag;
    reg          position_reached_flag;
    reg          proximity_flag;
    reg [TW-1:0] tick_cnt;
    reg          tick;
    reg [14:0]   win_cnt;
    reg [14:0]   hold_cnt;
    reg [14:0]   still_cnt;
    reg          qual_d;
    reg [3:0]    flags_d;

    wire [31:0] dev;
    wire [31:0] abs_dev;
    wire        below_reach;
    wire        below_proximity_flag;
    wire        held_below;
    reg         qual;
    wire        ref_complete;
    wire [3:0]  flags;
    wire [3:0]  rise;
    wire        wr_ctrl;

    // Deviation in the selected unit, magnitude only
    // The most negative input has no positive twin; its magnitude stays
    // at the top of the range and reads as a huge deviation, the safe
    // side for both comparisons.
    // Reach is strict and proximity inclusive, so equal thresholds still
    // raise proximity no later than reach.
    assign dev         = unit_sel ? DEV_REF_IN : DEV_ENC_IN; // RULE8
    assign abs_dev     = dev[31] ? (~dev + 32'h0000_0001) : dev;
    assign below_reach = abs_dev < {16'h0000, reach_thr};
    assign below_proximity_flag  = abs_dev <= {16'h0000, proximity_flag_thr};
    assign held_below  = below_reach && (still_cnt >= hold_ms);

    // Qualifying condition chosen by the select field
    // Select 3 reuses the hold time as its dwell time, so a hold of zero
    // makes it behave like select 2.
    always @* begin
        case (cond_sel) // RULE5
            2'h0:    qual = below_reach;
            2'h1:    qual = below_reach && REF_FILT_ZERO_IN;
            2'h2:    qual = below_reach && REF_ZERO_IN;
            2'h3:    qual = held_below && REF_ZERO_IN;
            default: qual = 1'b0;
        endcase
    end

    // Either reference source finished counts as complete
    // Sent follows these levels directly and drops when both go low
    assign ref_complete = MULTI_REF_ZERO_IN || INT_POS_DONE_IN; // RULE3
    // Flag vector in status bit order, shared by read and event logic
    assign flags = {proximity_flag, position_reached_flag,
                    command_sent_flag, motion_done_flag};
    assign rise  = flags & ~flags_d;
    assign wr_ctrl = WR_IN && (ADDR_IN == `PCF_ADDR_CTRL);

    // Millisecond tick; long count is a parameter so benches can shorten it
    // The first tick lands a full period after reset, so every window and
    // hold count carries up to one tick of jitter; shortening the period
    // scales all millisecond counts alike.
    always @(posedge REF_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            tick_cnt <= {TW{1'b0}};
            tick     <= 1'b0;
        end else if (tick_cnt == TICK_CYCLES[TW-1:0] - 1'b1) begin
            tick_cnt <= {TW{1'b0}};
            tick     <= 1'b1; // RULE15
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
            tick     <= 1'b0;
        end
    end

    // Command and motion completion
    // Done reads the registered reached flag, so it trails reached by one
    // cycle; the order keeps done from ever showing before reached on
    // the pins.
    always @(posedge REF_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            command_sent_flag <= 1'b0;
            motion_done_flag  <= 1'b0;
        end else begin
            command_sent_flag <= ref_complete; // RULE2
            motion_done_flag  <= POS_MODE_IN && ref_complete
                                 && position_reached_flag; // RULE1
        end
    end

    // Window filter, hold timer and proximity
    // The dwell counter saturates at the top of the legal span, so it
    // never wraps back under a long hold setting; a servo-off clears
    // the reached flag at once, ignoring any hold time.
    always @(posedge REF_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            win_cnt               <= 15'h0000;
            hold_cnt              <= 15'h0000;
            still_cnt             <= 15'h0000;
            qual_d                <= 1'b0;
            position_reached_flag <= 1'b0;
            proximity_flag        <= 1'b0;
        end else begin
            // Time spent continuously below threshold, for select 3
            if (!below_reach)
                still_cnt <= 15'h0000;
            else if (tick && still_cnt != `PCF_MAX_MS)
                still_cnt <= still_cnt + 15'h0001;
            qual_d <= qual;
            // Window restarts whenever the condition drops
            if (!qual || !POS_MODE_IN)
                win_cnt <= 15'h0000; // RULE15
            else if (tick && win_cnt < window_ms)
                win_cnt <= win_cnt + 15'h0001; // RULE9
            proximity_flag <= SERVO_ON_IN && below_proximity_flag; // RULE6 RULE12
            if (!SERVO_ON_IN) begin
                position_reached_flag <= 1'b0; // RULE12
                hold_cnt              <= 15'h0000;
            end else if (POS_MODE_IN && qual && win_cnt >= window_ms) begin
                position_reached_flag <= 1'b1; // RULE4 RULE9
                hold_cnt              <= 15'h0000;
            end else if (position_reached_flag) begin
                // Hold time runs only once the condition has let go
                if (hold_ms == 15'h0000) begin
                    // Stays set until the next reference arrives
                    if (NEW_REF_IN)
                        position_reached_flag <= 1'b0; // RULE11
                end else if (hold_cnt >= hold_ms) begin
                    position_reached_flag <= 1'b0; // RULE10
                end else if (tick) begin
                    hold_cnt <= hold_cnt + 15'h0001; // RULE10
                end
            end
        end
    end

    // Register writes; zero thresholds are lifted to one, long times clamped to the legal span
    // Time fields compare the whole word, so high bits above the field
    // cannot wrap a large setting into a small one.
    always @(posedge REF_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            cond_sel   <= `PCF_RST_COND;
            unit_sel   <= `PCF_RST_UNIT;
            reach_thr  <= `PCF_RST_REACH_THR; // RULE7
            proximity_flag_thr   <= `PCF_RST_PROXIMITY_FLAG_THR;
            window_ms  <= `PCF_RST_WINDOW;
            hold_ms    <= `PCF_RST_HOLD;
            polarity   <= `PCF_RST_POLARITY;
            irq_enable <= 4'h0;
        end else if (WR_IN) begin
            if (wr_ctrl) begin
                cond_sel <= WDATA_IN[`PCF_CTRL_COND_MSB:`PCF_CTRL_COND_LSB];
                unit_sel <= WDATA_IN[`PCF_CTRL_UNIT_BIT]; // RULE8
            end
            if (ADDR_IN == `PCF_ADDR_REACH_THR)
                reach_thr <= (WDATA_IN[15:0] == 16'h0000) ? `PCF_MIN_THR
                                                          : WDATA_IN[15:0]; // RULE7
            if (ADDR_IN == `PCF_ADDR_PROXIMITY_FLAG_THR)
                proximity_flag_thr <= (WDATA_IN[15:0] == 16'h0000) ? `PCF_MIN_THR
                                                         : WDATA_IN[15:0]; // RULE7
            if (ADDR_IN == `PCF_ADDR_WINDOW)
                window_ms <= (WDATA_IN > {17'h0_0000, `PCF_MAX_MS}) ? `PCF_MAX_MS
                                                                     : WDATA_IN[14:0];
            if (ADDR_IN == `PCF_ADDR_HOLD)
                hold_ms <= (WDATA_IN > {17'h0_0000, `PCF_MAX_MS}) ? `PCF_MAX_MS
                                                                   : WDATA_IN[14:0];
            if (ADDR_IN == `PCF_ADDR_POLARITY)
                polarity <= WDATA_IN[3:0]; // RULE13
            if (ADDR_IN == `PCF_ADDR_IRQ_ENABLE)
                irq_enable <= WDATA_IN[3:0];
        end
    end

    // Sticky rise events; a new rise beats a clear in the same cycle
    // Only rising flags set status bits, so a flag that stays high asks
    // for one service, not one per cycle; the interrupt pin lags the
    // status bits by one cycle.
    always @(posedge REF_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            flags_d    <= 4'h0;
            irq_status <= 4'h0;
            IRQ_OUT    <= 1'b0;
        end else begin
            flags_d <= flags;
            if (WR_IN && ADDR_IN == `PCF_ADDR_IRQ_CLEAR)
                irq_status <= (irq_status & ~WDATA_IN[3:0]) | rise;
            else
                irq_status <= irq_status | rise;
            IRQ_OUT <= |(irq_status & irq_enable);
        end
    end

    // Digital outputs with per-output active level (1 = active low)
    // A polarity write reaches the pins on the next edge, so the host
    // may see one cycle of the old level.
    always @(posedge REF_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            DONE_DO_OUT    <= 1'b0;
            SENT_DO_OUT    <= 1'b0;
            REACHED_DO_OUT <= 1'b0;
            PROXIMITY_FLAG_DO_OUT    <= 1'b0;
        end else begin
            DONE_DO_OUT    <= motion_done_flag ^ polarity[`PCF_BIT_DONE]; // RULE13
            SENT_DO_OUT    <= command_sent_flag ^ polarity[`PCF_BIT_SENT];
            REACHED_DO_OUT <= position_reached_flag ^ polarity[`PCF_BIT_REACHED];
            PROXIMITY_FLAG_DO_OUT    <= proximity_flag ^ polarity[`PCF_BIT_PROXIMITY_FLAG];
        end
    end

    // Read data one cycle after the strobe; unmapped reads give zero
    // Data drop back to zero after the answer cycle, so a stale word
    // is never mistaken for a fresh one.
    always @(posedge REF_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            RDATA_OUT <= 32'h0000_0000;
        end else if (RD_IN) begin
            case (ADDR_IN)
                `PCF_ADDR_CTRL:       RDATA_OUT <= {29'h0000_0000, unit_sel, cond_sel};
                `PCF_ADDR_REACH_THR:  RDATA_OUT <= {16'h0000, reach_thr};
                `PCF_ADDR_PROXIMITY_FLAG_THR:   RDATA_OUT <= {16'h0000, proximity_flag_thr};
                `PCF_ADDR_WINDOW:     RDATA_OUT <= {17'h0_0000, window_ms};
                `PCF_ADDR_HOLD:       RDATA_OUT <= {17'h0_0000, hold_ms};
                `PCF_ADDR_POLARITY:   RDATA_OUT <= {28'h000_0000, polarity};
                `PCF_ADDR_FLAGS:      RDATA_OUT <= {28'h000_0000, flags};
                `PCF_ADDR_IRQ_STATUS: RDATA_OUT <= {28'h000_0000, irq_status};
                `PCF_ADDR_IRQ_ENABLE: RDATA_OUT <= {28'h000_0000, irq_enable};
                default:              RDATA_OUT <= 32'h0000_0000;
            endcase
        end else begin
            RDATA_OUT <= 32'h0000_0000;
        end
    end

endmodule // pcf_flags

/* File: verilog/pcf_map.vh */
// Register map, field layout, reset values and timing constants of the completion flag block
`ifndef PCF_MAP_VH
`define PCF_MAP_VH

// Register offsets (byte addresses)
`define PCF_ADDR_CTRL        8'h00
`define PCF_ADDR_REACH_THR   8'h04
`define PCF_ADDR_PROXIMITY_FLAG_THR    8'h08
`define PCF_ADDR_WINDOW      8'h0C
`define PCF_ADDR_HOLD        8'h10
`define PCF_ADDR_POLARITY    8'h14
`define PCF_ADDR_FLAGS       8'h18
`define PCF_ADDR_IRQ_STATUS  8'h1C
`define PCF_ADDR_IRQ_CLEAR   8'h20
`define PCF_ADDR_IRQ_ENABLE  8'h24

// Control register fields
`define PCF_CTRL_COND_LSB    0
`define PCF_CTRL_COND_MSB    1
`define PCF_CTRL_UNIT_BIT    2

// Flag bit positions (flags, polarity and interrupt registers)
`define PCF_BIT_DONE         0
`define PCF_BIT_SENT         1
`define PCF_BIT_REACHED      2
`define PCF_BIT_PROXIMITY_FLAG         3

// Reset values
`define PCF_RST_COND         2'h0
`define PCF_RST_UNIT         1'h0
`define PCF_RST_REACH_THR    16'h16F0
`define PCF_RST_PROXIMITY_FLAG_THR     16'hFFFF
`define PCF_RST_WINDOW       15'h0000
`define PCF_RST_HOLD         15'h0000
`define PCF_RST_POLARITY     4'h0

// Limits
`define PCF_MAX_MS           15'h7530
`define PCF_MIN_THR          16'h0001

// Timing: millisecond tick at the 250 MHz clock
`define PCF_TICK_NS          1000000
`define PCF_CLK_NS           4
`define PCF_TICK_CYCLES      (`PCF_TICK_NS / `PCF_CLK_NS)

`endif
